// [logic/brc_pkg.sv]
// Shared constants for the bus request / cycle steal link.
// Assumes one 125 MHz clock shared by both ends.
package brc_pkg;
	localparam int unsigned MCYC_NS          = 1000;
	localparam int unsigned CLK_NS           = 8;
	// Machine cycle length in clocks, rounded down
	localparam int unsigned MCYC_CLKS        = (MCYC_NS / CLK_NS < 1) ? 1 : MCYC_NS / CLK_NS;
	localparam logic [7:0]  MCYC_LAST        = 8'(MCYC_CLKS - 1);
	localparam logic [3:0]  STEAL_PERIOD     = 4'he;
	localparam logic [3:0]  IDLE_CLEAR       = 4'h3;
	localparam logic [3:0]  IDLE_SAFE        = 4'h4;
	localparam logic [3:0]  LOW_DELAY_MIN    = 4'h6;
	localparam logic [3:0]  LOW_DELAY_MAX    = 4'hd;
	localparam logic [3:0]  BURST_MAX        = 4'he;

	typedef enum logic [1:0] {
		BRC_CPU  = 2'b00,
		BRC_WAIT = 2'b01,
		BRC_DMA  = 2'b10,
		BRC_DEAD = 2'b11
	} brc_state_type;
endpackage : brc_pkg

// [logic/brc_if.sv]
// Link between processor-side arbiter and DMA master.
// Request is active low; grant pins are plain levels.
`timescale 1ns/1ps
interface brc_if;
	logic dma_bus_request_n;
	logic bus_available;
	logic bus_state;
	logic mcyc_end;

	modport cpu (input dma_bus_request_n, output bus_available, output bus_state,
		output mcyc_end);
	modport master (output dma_bus_request_n, input bus_available, input bus_state,
		input mcyc_end);
endinterface : brc_if

// [logic/brc_cpu_arb.sv]
// Processor-side arbiter for the combined DMA / bus request input.
// Assumes the master is on the same clock but its request is resynchronised anyway.
// Grants and cycle strobe come straight from flops.
// Functional notes
// RQ1: sample request at every machine cycle end
// RQ2: low request gives DMA, grants high
// RQ3: extra clock delay after 6-13 low/3 high
// RQ4: steal counter cleared after 3 idle cycles
// RQ5: master keeps request high 4 cycles
// RQ6: reclaim bus every 14 DMA cycles
// RQ7: halt-burst limited to 14 transfers
// RQ8: master stops when bus-available falls
// RQ9: longer bursts use the halt input; the master has no halt input and clamps longer counts to 14
// RQ10: release grants, then one dead cycle
`timescale 1ns/1ps
module brc_cpu_arb
	import brc_pkg::*;
(
	input  wire logic clk,
	input  wire logic srst,
	brc_if.cpu        link,
	output logic      dma_active,
	output logic      steal_active
);
	import brc_pkg::*;

	function automatic logic [3:0] sat_inc(input logic [3:0] v);
		sat_inc = (v == 4'hf) ? v : v + 4'h1;
	endfunction : sat_inc

	logic          req_s1_q, req_s2_q;
	logic [7:0]    div_q, div_d;
	logic          mend;
	brc_state_type st_q, st_d;
	logic [3:0]    low_q, low_d, high_q, high_d, steal_q, steal_d;
	logic          ba_q, ba_d, steal_q2, steal_d2;
	logic          mend_q;
	logic          reclaim;

	// Two-flop synchroniser
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			req_s1_q <= 1'b1;
			req_s2_q <= 1'b1;
		end
		else
		begin
			req_s1_q <= link.dma_bus_request_n;
			req_s2_q <= req_s1_q;
		end
	end

	// Machine cycle divider
	always_comb
	begin
		div_d = mend ? 8'h00 : div_q + 8'h01;
	end
	assign mend = (div_q == MCYC_LAST);

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			div_q  <= 8'h00;
			mend_q <= 1'b0;
		end
		else
		begin
			div_q  <= div_d;
			mend_q <= mend;
		end
	end

	// RQ6: reverse steal due now
	assign reclaim = mend && (st_q == BRC_DMA) && !req_s2_q
		&& (sat_inc(steal_q) >= STEAL_PERIOD);

	// Request history and steal count
	always_comb
	begin
		low_d   = low_q;
		high_d  = high_q;
		steal_d = steal_q;
		if (mend)
		begin
			// RQ1: machine cycle sample
			if (!req_s2_q)
			begin
				low_d  = sat_inc(low_q);
				high_d = 4'h0;
			end
			else
			begin
				high_d = sat_inc(high_q);
				low_d  = 4'h0;
			end
			// RQ6: count DMA cycles
			if (reclaim)
				steal_d = 4'h0;
			else if (st_q == BRC_DMA)
				steal_d = sat_inc(steal_q);
			// RQ4: idle clears counter
			else if (req_s2_q && sat_inc(high_q) >= IDLE_CLEAR)
				steal_d = 4'h0;
		end
	end

	// Counter registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			low_q   <= 4'h0;
			high_q  <= 4'hf;
			steal_q <= 4'h0;
		end
		else
		begin
			low_q   <= low_d;
			high_q  <= high_d;
			steal_q <= steal_d;
		end
	end

	// Arbitration state and grant
	always_comb
	begin
		st_d     = st_q;
		ba_d     = ba_q;
		steal_d2 = steal_q2;
		// RQ1: decide at cycle end
		if (mend)
		begin
			case (st_q)
				BRC_CPU:
				begin
					steal_d2 = 1'b0;
					if (!req_s2_q)
					begin
						// RQ3: delayed grant cases
						if ((low_q >= LOW_DELAY_MIN && low_q <= LOW_DELAY_MAX)
							|| high_q == IDLE_CLEAR)
							st_d = BRC_WAIT;
						else
						begin
							// RQ2: grant bus
							st_d = BRC_DMA;
							ba_d = 1'b1;
						end
					end
				end
				BRC_DMA:
				begin
					// RQ6: periodic reverse steal
					if (reclaim)
					begin
						st_d     = BRC_DEAD;
						ba_d     = 1'b0;
						steal_d2 = 1'b1;
					end
					// RQ10: release then dead cycle
					else if (req_s2_q)
					begin
						st_d = BRC_DEAD;
						ba_d = 1'b0;
					end
				end
				BRC_DEAD:
					st_d = BRC_CPU;
				default:
					st_d = BRC_CPU;
			endcase
		end
		else if (st_q == BRC_WAIT && div_q == 8'h00)
		begin
			// RQ3: one clock late
			st_d = BRC_DMA;
			ba_d = 1'b1;
		end
	end

	// State registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_q     <= BRC_CPU;
			ba_q     <= 1'b0;
			steal_q2 <= 1'b0;
		end
		else
		begin
			st_q     <= st_d;
			ba_q     <= ba_d;
			steal_q2 <= steal_d2;
		end
	end

	// Both grant pins follow one flop
	assign link.bus_available = ba_q;
	assign link.bus_state     = ba_q;
	assign link.mcyc_end      = mend_q;
	assign dma_active         = ba_q;
	assign steal_active       = steal_q2;
endmodule : brc_cpu_arb

// [logic/brc_dma_master.sv]
// External DMA master end: requests bursts, stops on grant loss.
// Assumes the arbiter supplies a machine cycle end strobe.
`timescale 1ns/1ps
module brc_dma_master
	import brc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       srst,
	brc_if.master           link,
	input  wire logic       start,
	input  wire logic [3:0] count,
	output logic            busy,
	output logic            xfer
);
	import brc_pkg::*;

	logic       req_n_q, req_n_d, busy_q, busy_d, xfer_q, xfer_d;
	logic [3:0] left_q, left_d, idle_q, idle_d;
	logic       ba_s1_q, ba_s2_q;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ba_s1_q <= 1'b0;
			ba_s2_q <= 1'b0;
		end
		else
		begin
			ba_s1_q <= link.bus_available;
			ba_s2_q <= ba_s1_q;
		end
	end

	always_comb
	begin
		req_n_d = req_n_q;
		busy_d  = busy_q;
		left_d  = left_q;
		idle_d  = idle_q;
		xfer_d  = 1'b0;
		if (link.mcyc_end)
		begin
			if (req_n_q && idle_q != 4'hf)
				idle_d = idle_q + 4'h1;
			// RQ5: idle spacing; RQ7: limit 14; RQ9: longer needs halt; no halt input here, longer counts clamp to 14
			if (!busy_q && start && idle_q >= IDLE_SAFE && count != 4'h0)
			begin
				busy_d  = 1'b1;
				req_n_d = 1'b0;
				left_d  = (count > BURST_MAX) ? BURST_MAX : count;
			end
			// RQ8: transfer only while granted
			else if (busy_q && ba_s2_q && link.bus_available)
			begin
				xfer_d = 1'b1;
				left_d = left_q - 4'h1;
				if (left_q == 4'h1)
				begin
					busy_d  = 1'b0;
					req_n_d = 1'b1;
					idle_d  = 4'h0;
				end
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			req_n_q <= 1'b1;
			busy_q  <= 1'b0;
			xfer_q  <= 1'b0;
			left_q  <= 4'h0;
			idle_q  <= 4'hf;
		end
		else
		begin
			req_n_q <= req_n_d;
			busy_q  <= busy_d;
			xfer_q  <= xfer_d;
			left_q  <= left_d;
			idle_q  <= idle_d;
		end
	end

	assign link.dma_bus_request_n = req_n_q;
	assign busy                   = busy_q;
	assign xfer                   = xfer_q;
endmodule : brc_dma_master

// [verification/brc_link_checker.sv]
// Checks held on the request and grant link.
// Assumes 125-clock machine cycles from the arbiter.
`timescale 1ns/1ps
module brc_link_checker
(
	input wire logic clk,
	input wire logic srst,
	input wire logic dma_bus_request_n,
	input wire logic bus_available,
	input wire logic bus_state,
	input wire logic mcyc_end
);
	logic [3:0] dma_q;
	logic [9:0] hi_q;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// Cycle ends under grant, clocks of idle request
	always_ff @(posedge clk)
	begin
		if (srst || !bus_available) dma_q <= 4'h0;
		else if (mcyc_end && dma_q != 4'hf) dma_q <= dma_q + 4'h1;
		if (srst) hi_q <= 10'h3ff;
		else if (!dma_bus_request_n) hi_q <= 10'h000;
		else if (hi_q != 10'h3ff) hi_q <= hi_q + 10'h001;
	end
	a_grant_pair_equal: assert property (bus_available == bus_state)
		else $error("grant pins differ");
	a_grant_at_end: assert property ($rose(bus_available) |->
		mcyc_end || $past(mcyc_end) || $past(mcyc_end, 2)) else $error("grant off cycle end");
	a_cycle_period: assert property (mcyc_end |-> ##125 mcyc_end)
		else $error("cycle end spacing");
	a_release_bound: assert property ($rose(dma_bus_request_n) |-> ##[0:260] !bus_available)
		else $error("grant kept after release");
	a_dead_cycle: assert property ($fell(bus_available) |=> !bus_available [*8])
		else $error("no dead cycle");
	a_steal_bound: assert property (dma_q <= 4'he)
		else $error("more than 14 dma cycles");
	a_idle_no_grant: assert property (hi_q >= 10'd260 |-> !bus_available)
		else $error("grant without request");
	a_request_spacing: assert property ($fell(dma_bus_request_n) |-> $past(hi_q) >= 10'd490)
		else $error("request spacing short");
	cover property ($rose(bus_available));
	cover property (dma_q == 4'he);
	cover property ($fell(dma_bus_request_n) && hi_q != 10'h3ff);
endmodule : brc_link_checker

// [verification/bus_request_cycle_steal_test.sv]
// Bench joining the arbiter and the DMA master on one link.
// Assumes the master paces bursts by the arbiter cycle strobe.
`timescale 1ns/1ps
module bus_request_cycle_steal_test;
	import brc_pkg::*;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       start = 1'b0;
	logic [3:0] count = 4'h0;
	logic       busy;
	logic       xfer;
	logic       dma_active;
	logic       steal_active;
	int         mismatches = 0;
	int         comparisons = 0;
	int         cycles = 0;
	brc_if link ();
	brc_cpu_arb brc_cpu_arb_inst (.clk(clk), .srst(srst), .link(link),
		.dma_active(dma_active), .steal_active(steal_active));
	brc_dma_master brc_dma_master_inst (.clk(clk), .srst(srst), .link(link),
		.start(start), .count(count), .busy(busy), .xfer(xfer));
	brc_link_checker brc_link_checker_inst (.clk(clk), .srst(srst),
		.dma_bus_request_n(link.dma_bus_request_n), .bus_available(link.bus_available),
		.bus_state(link.bus_state), .mcyc_end(link.mcyc_end));
	always #4 clk = ~clk;
	task complete_run;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	task compare(input logic [4:0] got, input logic [4:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : compare
	// One burst request; counts transfers, grant and reverse steal seen
	task burst(input logic [3:0] n, input logic [4:0] exp, input logic exp_steal);
		logic [4:0] seen;
		logic       granted;
		logic       stolen;
		seen = 5'h00;
		granted = 1'b1;
		stolen = 1'b0;
		@(posedge clk);
		start <= 1'b1;
		count <= n;
		for (int i = 0; i < 2000 && busy !== 1'b1; i++)
		begin
			@(posedge clk);
		end
		start <= 1'b0;
		while (busy === 1'b1)
		begin
			@(posedge clk);
			if (xfer === 1'b1) seen = seen + 5'h01;
			if (xfer === 1'b1 && dma_active !== 1'b1) granted = 1'b0;
			if (steal_active === 1'b1) stolen = 1'b1;
		end
		compare(seen, exp);
		compare({4'h0, granted}, 5'h01);
		compare({4'h0, stolen}, {4'h0, exp_steal});
	endtask : burst
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches++;
			complete_run();
		end
	end
	initial
	begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		burst(4'h3, 5'h03, 1'b0);
		burst(4'he, 5'h0e, 1'b1);
		burst(4'h0, 5'h00, 1'b0);
		burst(4'hf, 5'h0e, 1'b1);
		burst(4'h1, 5'h01, 1'b0);
		complete_run();
	end
endmodule : bus_request_cycle_steal_test
